// ==== pkg/sar_adc_pkg.sv ====
// Purpose: Shared constants and types for the converter control block
// Assumes: 32-bit AXI4-Lite register bus, 100 MHz system clock
// Notes: Control register layout follows the converter control word

package sar_adc_pkg;

  // Register byte offsets
  localparam logic [7:0] CONVERTER_CONTROL_REG = 8'h00;
  localparam logic [7:0] CHANNEL_SELECT_REG = 8'h04;
  localparam logic [7:0] CONVERTER_RESULT_REG = 8'h08;
  localparam logic [7:0] IRQ_STATUS_REG = 8'h0C;
  localparam logic [7:0] IRQ_MASK_REG = 8'h10;

  // Control and result field positions
  localparam int CTRL_TEMP_BIT = 13;
  localparam int CTRL_CLK_LSB = 10;
  localparam int CTRL_ACQ_LSB = 8;
  localparam int CTRL_START_BIT = 7;
  localparam int CTRL_DIFF_BIT = 6;
  localparam int RESULT_LSB = 16;
  localparam int RESULT_SIGN_LSB = 28;

  // Values after reset: divider two, eight acquisition clocks
  localparam logic [15:0] CTRL_RESET = 16'h0600;
  localparam logic [3:0] CHAN_RESET = 4'h0;

  // Conversion kinds in control bits 2:0
  localparam logic [2:0] CONV_NONE = 3'h0;
  localparam logic [2:0] CONV_EXT_PIN = 3'h1;
  localparam logic [2:0] CONV_TIMER_A = 3'h2;
  localparam logic [2:0] CONV_TIMER_B = 3'h3;
  localparam logic [2:0] CONV_SINGLE = 3'h4;
  localparam logic [2:0] CONV_CONTINUOUS = 3'h5;
  localparam logic [2:0] CONV_LOGIC_ARRAY = 3'h6;

  // Multiplexer code of the die temperature channel
  localparam logic [3:0] TEMP_CHANNEL = 4'hC;

  // Result width, converter clock counts and search seed
  localparam int RESULT_BITS = 12;
  localparam logic [4:0] TRIAL_TICKS = 5'h0C;
  localparam logic [4:0] EXTRA_TICKS = 5'h13;
  localparam logic [11:0] SAR_MSB = 12'h800;

  // Throughput: at divider one and two acquisition clocks one sample is
  // 21 converter clocks, so a 41.78 MHz source gives about 2 MSPS
  localparam real SYS_CLK_MHZ = 100.0;
  localparam real TARGET_MSPS = 1.0;
  localparam int SAMPLE_BUDGET_CYCLES = int'(SYS_CLK_MHZ / TARGET_MSPS);

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ACQ = 4'b0010,
    ST_CONV = 4'b0100,
    ST_SPARE = 4'b1000
  } conv_state_t;

endpackage

// ==== src/pin_sync.sv ====
// Purpose: Bring an asynchronous trigger pin into the clock domain
// Assumes: Pin may change at any time
// Notes: A change counts once the second and third stages agree
`timescale 1ns/100ps
`default_nettype none

module pin_sync (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Pin and qualified rising edge
  input wire logic pinIn,
  output logic risePulse
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic pulse;
  } sync_t;

  sync_t st_q, st_d;

  // First stage feeds only the second
  always_comb begin
    st_d = st_q;
    st_d.s1 = pinIn;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.pulse = 1'b0;
    if (st_q.s2 == st_q.s3) begin
      st_d.level = st_q.s3;
      st_d.pulse = st_q.s3 & ~st_q.level;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign risePulse = st_q.pulse;

  AST_PULSE_ONE: assert property (@(posedge sys_clk) disable iff (!resetn)
    st_q.pulse |=> !st_q.pulse) else $error("trigger pulse longer than one cycle");

endmodule
`default_nettype wire

// ==== src/sar_step.sv ====
// Purpose: Successive-approximation register, one bit decision per step
// Assumes: Comparator output is latched on the system clock
// Notes: High comparator keeps the bit under trial
`timescale 1ns/100ps
`default_nettype none

module sar_step
  import sar_adc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Control
  input wire logic start,
  input wire logic step,
  input wire logic compIn,
  // Trial code and finish
  output logic [11:0] code,
  output logic done
);

  typedef struct packed {
    logic [11:0] code;
    logic [11:0] mask;
    logic done;
  } sar_t;

  sar_t st_q, st_d;

  // Binary search from the top bit down
  always_comb begin
    st_d = st_q;
    if (start) begin
      st_d.code = SAR_MSB;
      st_d.mask = SAR_MSB;
      st_d.done = 1'b0;
    end else if (step && st_q.mask != 12'h000) begin
      if (!compIn) begin
        st_d.code = (st_q.code & ~st_q.mask) | (st_q.mask >> 1);
      end else begin
        st_d.code = st_q.code | (st_q.mask >> 1);
      end
      st_d.mask = st_q.mask >> 1;
      st_d.done = st_q.mask[0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign code = st_q.code;
  assign done = st_q.done;

  AST_SAR_LAST: assert property (@(posedge sys_clk) disable iff (!resetn)
    (step && !start && st_q.mask == 12'h001) |=> done) else $error("search did not end");
  AST_SAR_SEED: assert property (@(posedge sys_clk) disable iff (!resetn)
    start |=> (code == SAR_MSB) && !done) else $error("search seed wrong");

endmodule
`default_nettype wire

// ==== src/sar_adc_conversion_control.sv ====
// Purpose: Control of a multichannel 12-bit successive-approximation converter
// Assumes: AXI4-Lite slave, single clock, comparator on the system clock
// Notes: Conversion kinds and timing are set in the control register
// Summary of operation
// - 12-bit result by bitwise successive approximation
// - Single-ended or differential applied every conversion
// - Software single or continuous conversions
// - Pin, logic array, timer overflows trigger
// - Temperature channel selectable like others
// - Single-ended result is straight binary
// - Timing allows one megasample per second
// - Differential result twos complement, shifted right
// - Result in bits 16-27, sign above
// - Reset: eight acquisition clocks, divider two
// - Start enable gates starts, not continuous run
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none

module sar_adc_conversion_control
  import sar_adc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Trigger sources
  input wire logic extConversionTriggerPin,
  input wire logic logicArrayOut,
  input wire logic generalTimerAOvf,
  input wire logic generalTimerBOvf,
  // Analog front end
  input wire logic compIn,
  output logic [11:0] dacCode,
  output logic sampleHold,
  output logic [3:0] muxSel,
  output logic diffSel,
  // Interrupt
  output logic irq
);

  typedef struct packed {
    logic awReady;
    logic wReady;
    logic awHave;
    logic wHave;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [15:0] ctrl;
    logic [3:0] chan;
    logic mask;
    logic done;
    logic irq;
    logic [31:0] result;
    logic [4:0] divCnt;
    conv_state_t state;
    logic [4:0] cnt;
    logic cont;
    logic sampleHold;
    logic [3:0] muxSel;
    logic diffSel;
    logic sarStart;
    logic sarStep;
    logic laPrev;
  } ctl_t;

  localparam ctl_t CTL_RESET = '{
    ctrl: CTRL_RESET,
    chan: CHAN_RESET,
    state: ST_IDLE,
    default: '0
  };

  ctl_t st_q, st_d;
  logic extPulse;
  logic [11:0] sarCode;
  logic sarDone;

  // Trigger pin is asynchronous
  pin_sync u_pin_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .pinIn(extConversionTriggerPin),
    .risePulse(extPulse)
  );

  sar_step u_sar_step (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .start(st_q.sarStart),
    .step(st_q.sarStep),
    .compIn(compIn),
    .code(sarCode),
    .done(sarDone)
  );

  // Converter clock divider limit; unused codes fall back to /32
  function automatic logic [4:0] divLimit(input logic [2:0] sel);
    case (sel)
      3'h0: divLimit = 5'h00;
      3'h1: divLimit = 5'h01;
      3'h2: divLimit = 5'h03;
      3'h3: divLimit = 5'h07;
      3'h4: divLimit = 5'h0F;
      default: divLimit = 5'h1F;
    endcase
  endfunction

  // Last acquisition tick index: 2, 4, 8 or 16 clocks
  function automatic logic [4:0] acqLast(input logic [1:0] sel);
    acqLast = 5'((6'h02 << sel) - 6'h01);
  endfunction

  // Byte-lane merge for register writes
  function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0] strb);
    laneMerge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        laneMerge[8*i +: 8] = data[8*i +: 8];
      end
    end
  endfunction

  // Result word: straight binary or shifted twos complement, sign filled
  function automatic logic [31:0] formatResult(input logic [11:0] raw,
                                               input logic diff);
    logic [11:0] val;
    val = raw;
    formatResult = '0;
    if (diff) begin
      val = {~raw[11], ~raw[11], raw[10:1]};
    end
    formatResult[RESULT_LSB +: RESULT_BITS] = val;
    formatResult[31:RESULT_SIGN_LSB] = {4{diff & val[11]}};
  endfunction

  logic tick;
  logic doWrite;
  logic wrCtrl;
  logic [31:0] ctrlMerged;
  logic [2:0] convKind;
  logic swReq;
  logic hwReq;
  logic laRise;
  logic writeBack;

  // Everything happens in one next-state process
  always_comb begin
    st_d = st_q;
    st_d.sarStart = 1'b0;
    st_d.sarStep = 1'b0;
    tick = (st_q.divCnt == divLimit(st_q.ctrl[CTRL_CLK_LSB +: 3]));
    st_d.divCnt = tick ? 5'h00 : st_q.divCnt + 5'h01;
    laRise = logicArrayOut & ~st_q.laPrev;
    st_d.laPrev = logicArrayOut;
    writeBack = 1'b0;
    wrCtrl = 1'b0;
    ctrlMerged = laneMerge({16'h0000, st_q.ctrl}, st_q.wData, st_q.wStrb);

    // Write address and data taken in either order
    if (awvalid && st_q.awReady) begin
      st_d.awHave = 1'b1;
      st_d.awAddr = awaddr;
    end
    if (wvalid && st_q.wReady) begin
      st_d.wHave = 1'b1;
      st_d.wData = wdata;
      st_d.wStrb = wstrb;
    end
    if (st_q.bValid && bready) begin
      st_d.bValid = 1'b0;
    end
    doWrite = st_q.awHave && st_q.wHave && !st_q.bValid;
    if (doWrite) begin
      st_d.awHave = 1'b0;
      st_d.wHave = 1'b0;
      st_d.bValid = 1'b1;
      st_d.bResp = RESP_OKAY;
      case (st_q.awAddr)
        CONVERTER_CONTROL_REG: begin
          st_d.ctrl = ctrlMerged[15:0] & 16'h3FFF;
          wrCtrl = 1'b1;
        end
        CHANNEL_SELECT_REG: begin
          st_d.chan = st_q.wStrb[0] ? st_q.wData[3:0] : st_q.chan;
        end
        IRQ_MASK_REG: begin
          st_d.mask = st_q.wStrb[0] ? st_q.wData[0] : st_q.mask;
        end
        CONVERTER_RESULT_REG, IRQ_STATUS_REG: begin
          st_d.bResp = RESP_OKAY;
        end
        default: begin
          st_d.bResp = RESP_SLVERR;
        end
      endcase
    end

    // Reads; a status read clears done before any new set below
    if (st_q.rValid && rready) begin
      st_d.rValid = 1'b0;
    end
    if (arvalid && st_q.arReady) begin
      st_d.rValid = 1'b1;
      st_d.rResp = RESP_OKAY;
      case (araddr)
        CONVERTER_CONTROL_REG: st_d.rData = {16'h0000, st_q.ctrl};
        CHANNEL_SELECT_REG: st_d.rData = {28'h0000000, st_q.chan};
        CONVERTER_RESULT_REG: st_d.rData = st_q.result;
        IRQ_STATUS_REG: begin
          st_d.rData = {30'h00000000, st_q.state != ST_IDLE, st_q.done};
          st_d.done = 1'b0;
        end
        IRQ_MASK_REG: st_d.rData = {31'h00000000, st_q.mask};
        default: begin
          st_d.rData = 32'h00000000;
          st_d.rResp = RESP_SLVERR;
        end
      endcase
    end

    // Software start requests use the freshly written control word, trigger requests the held one
    convKind = st_d.ctrl[2:0];
    swReq = wrCtrl && st_d.ctrl[CTRL_START_BIT] &&
            (convKind == CONV_SINGLE || convKind == CONV_CONTINUOUS);
    hwReq = st_q.ctrl[CTRL_START_BIT] && (
            (st_q.ctrl[2:0] == CONV_EXT_PIN && extPulse) ||
            (st_q.ctrl[2:0] == CONV_TIMER_A && generalTimerAOvf) ||
            (st_q.ctrl[2:0] == CONV_TIMER_B && generalTimerBOvf) ||
            (st_q.ctrl[2:0] == CONV_LOGIC_ARRAY && laRise));

    // Conversion sequencer, paced by converter clock ticks
    case (st_q.state)
      ST_IDLE: begin
        if (swReq || hwReq) begin
          st_d.state = ST_ACQ;
          st_d.cnt = 5'h00;
          st_d.cont = swReq && convKind == CONV_CONTINUOUS;
          st_d.sampleHold = 1'b1;
          st_d.muxSel = st_d.ctrl[CTRL_TEMP_BIT] ? TEMP_CHANNEL : st_d.chan;
          st_d.diffSel = st_d.ctrl[CTRL_DIFF_BIT];
        end
      end
      ST_ACQ: begin
        if (tick) begin
          if (st_q.cnt == acqLast(st_q.ctrl[CTRL_ACQ_LSB +: 2])) begin
            st_d.state = ST_CONV;
            st_d.cnt = 5'h00;
            st_d.sampleHold = 1'b0;
            st_d.sarStart = 1'b1;
          end else begin
            st_d.cnt = st_q.cnt + 5'h01;
          end
        end
      end
      ST_CONV: begin
        if (tick) begin
          st_d.sarStep = (st_q.cnt < TRIAL_TICKS);
          if (st_q.cnt == EXTRA_TICKS - 5'h01) begin
            writeBack = 1'b1;
            st_d.result = formatResult(sarCode, st_q.diffSel);
            st_d.done = 1'b1;
            st_d.cnt = 5'h00;
            // Clearing start enable does not end a continuous run
            if (st_q.cont && st_q.ctrl[2:0] == CONV_CONTINUOUS) begin
              st_d.state = ST_ACQ;
              st_d.sampleHold = 1'b1;
              st_d.muxSel = st_q.ctrl[CTRL_TEMP_BIT] ? TEMP_CHANNEL : st_q.chan;
              st_d.diffSel = st_q.ctrl[CTRL_DIFF_BIT];
            end else begin
              st_d.state = ST_IDLE;
              st_d.cont = 1'b0;
            end
          end else begin
            st_d.cnt = st_q.cnt + 5'h01;
          end
        end
      end
      default: begin
        st_d.state = ST_IDLE;
        st_d.sampleHold = 1'b0;
        st_d.cont = 1'b0;
      end
    endcase

    // Ready flags stay low while a transfer is held
    st_d.awReady = !st_d.awHave && !st_d.bValid;
    st_d.wReady = !st_d.wHave && !st_d.bValid;
    st_d.arReady = !st_d.rValid;
    st_d.irq = st_d.done & st_d.mask;
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_q <= CTL_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from state flops
  assign awready = st_q.awReady;
  assign wready = st_q.wReady;
  assign bvalid = st_q.bValid;
  assign bresp = st_q.bResp;
  assign arready = st_q.arReady;
  assign rvalid = st_q.rValid;
  assign rdata = st_q.rData;
  assign rresp = st_q.rResp;
  assign dacCode = sarCode;
  assign sampleHold = st_q.sampleHold;
  assign muxSel = st_q.muxSel;
  assign diffSel = st_q.diffSel;
  assign irq = st_q.irq;

  sequence seqWriteBack;
    st_q.state == ST_CONV && tick && st_q.cnt == EXTRA_TICKS - 5'h01;
  endsequence

  sequence seqIdleBlocked;
    st_q.state == ST_IDLE && !st_q.ctrl[CTRL_START_BIT] && !wrCtrl;
  endsequence

  property pDoneAfterWrite;
    @(posedge sys_clk) disable iff (!resetn)
    seqWriteBack |=> st_q.done ##1 (st_q.irq == st_q.mask || !st_q.done);
  endproperty

  AST_DONE_SET: assert property (pDoneAfterWrite) else $error("done not raised");
  AST_SE_BINARY: assert property (@(posedge sys_clk) disable iff (!resetn)
    (seqWriteBack and !st_q.diffSel) |=> st_q.result == {4'h0, $past(sarCode), 16'h0000})
    else $error("single-ended result wrong");
  AST_DIFF_TC: assert property (@(posedge sys_clk) disable iff (!resetn)
    (seqWriteBack and st_q.diffSel) |=> st_q.result[27:16] ==
    {~$past(sarCode[11]), ~$past(sarCode[11]), $past(sarCode[10:1])})
    else $error("differential coding wrong");
  AST_SIGN_FILL: assert property (@(posedge sys_clk) disable iff (!resetn)
    seqWriteBack |=> st_q.result[31:28] == {4{st_q.result[27] & $past(st_q.diffSel)}})
    else $error("sign fill wrong");
  AST_START_BLOCK: assert property (@(posedge sys_clk) disable iff (!resetn)
    seqIdleBlocked |=> st_q.state == ST_IDLE) else $error("start while disabled");
  AST_RESET_CTRL: assert property (@(posedge sys_clk)
    $rose(resetn) |-> st_q.ctrl == CTRL_RESET && st_q.state == ST_IDLE)
    else $error("control reset value wrong");
  AST_SW_START: assert property (@(posedge sys_clk) disable iff (!resetn)
    (st_q.state == ST_IDLE && swReq) |=> st_q.state == ST_ACQ && st_q.sampleHold)
    else $error("software start missed");
  AST_HW_TRIG: assert property (@(posedge sys_clk) disable iff (!resetn)
    (st_q.state == ST_IDLE && hwReq) |=> st_q.state == ST_ACQ)
    else $error("hardware trigger missed");
  AST_TEMP_MUX: assert property (@(posedge sys_clk) disable iff (!resetn)
    (st_q.state == ST_IDLE && (swReq || hwReq) && st_d.ctrl[CTRL_TEMP_BIT])
    |=> muxSel == TEMP_CHANNEL) else $error("temperature channel not routed");
  AST_DIFF_HOLD: assert property (@(posedge sys_clk) disable iff (!resetn)
    (st_q.state == ST_ACQ && $stable(st_q.state)) |-> $stable(diffSel))
    else $error("input mode changed mid conversion");
  // A control write may swap the divider under the check, so that cycle is left out
  AST_TICK_PACE: assert property (@(posedge sys_clk) disable iff (!resetn)
    (st_q.ctrl[12:10] == 3'h1 && tick && !wrCtrl) |=> !tick)
    else $error("divider two wrong");
  // Write-back only once the search has decided every bit
  AST_SEARCH_DONE: assert property (@(posedge sys_clk) disable iff (!resetn)
    writeBack |-> sarDone) else $error("result written before search end");

endmodule
`default_nettype wire

// ==== sim/analog_source_model.sv ====
// Purpose: Analog sources behind the input multiplexer, seen through the comparator
// Assumes: Comparator settles within one system clock of a new trial code
// Notes: Every channel sits at its own level, so a wrong channel shows in the result
`timescale 1ns/100ps
`default_nettype none

module analog_source_model (
  // Level chosen by the bench
  input wire logic [11:0] levelBase,
  // Converter side
  input wire logic [3:0] muxSel,
  input wire logic [11:0] dacCode,
  output logic compIn
);
  logic [11:0] level;

  // Channel level, die sensor on its own code like any other input
  assign level = levelBase + 12'(muxSel) * 12'h111;
  // High keeps the trial bit; differential pairs already arrive as offset code
  assign compIn = (level >= dacCode);
endmodule
`default_nettype wire

// ==== sim/sar_adc_conversion_control_test.sv ====
// Purpose: Self-checking bench for the converter control block
// Assumes: Single 100 MHz clock, comparator model on the analog side
// Notes: Results are noted in queues and compared when the bus returns them
`timescale 1ns/100ps
`default_nettype none

module sar_adc_conversion_control_test;
  import sar_adc_pkg::*;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} rd_note_t;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0, muxSel, expMux;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, compIn, sampleHold, diffSel, irq, expDiff;
  logic [1:0] bresp, rresp;
  logic extConversionTriggerPin = 0, logicArrayOut = 0, generalTimerAOvf = 0;
  logic generalTimerBOvf = 0;
  logic [11:0] dacCode, levelBase = 12'h0;
  logic [15:0] ctl;
  logic [2:0] kinds [4] = '{CONV_EXT_PIN, CONV_TIMER_A, CONV_TIMER_B, CONV_LOGIC_ARRAY};
  int fail_count = 0, checks = 0, n;
  logic [1:0] bq [$];
  rd_note_t rq [$];
  rd_note_t note;

  always #5 sys_clk = ~sys_clk;

  sar_adc_conversion_control sar_adc_conversion_control_i (.sys_clk(sys_clk), .resetn(resetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .extConversionTriggerPin(extConversionTriggerPin),
    .logicArrayOut(logicArrayOut), .generalTimerAOvf(generalTimerAOvf),
    .generalTimerBOvf(generalTimerBOvf), .compIn(compIn), .dacCode(dacCode),
    .sampleHold(sampleHold), .muxSel(muxSel), .diffSel(diffSel), .irq(irq));

  analog_source_model analog_source_model_i (.levelBase(levelBase), .muxSel(muxSel),
    .dacCode(dacCode), .compIn(compIn));

  task automatic err(input string s);
    fail_count++;
    $display("[ERR] %0t %s", $time, s);
  endtask

  task automatic conclude();
    if (fail_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check1(input logic got, input logic exp, input string s);
    checks++;
    if (got !== exp) err(s);
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (n == 200) begin err("write hung"); conclude(); end
  endtask

  // Read: expected word and care mask noted before the request
  task automatic axiRead(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                         input logic [1:0] r);
    rq.push_back('{d, m, r});
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (n == 200) begin err("read hung"); conclude(); end
  endtask

  // Responses are judged at the handshake edge, oldest note first
  always @(posedge sys_clk) begin
    if (bvalid && bready && bq.size() > 0) begin
      checks++;
      if (bresp !== bq.pop_front()) err("write response wrong");
    end
    if (rvalid && rready && rq.size() > 0) begin
      note = rq.pop_front();
      checks++;
      if ((rdata & note.m) !== (note.d & note.m) || rresp !== note.r) err("read data wrong");
    end
  end

  // Channel and mode must hold for the whole acquisition
  always @(negedge sys_clk) begin
    if (sampleHold === 1'b1) begin
      check1(muxSel === expMux && diffSel === expDiff, 1, "mux or mode");
    end
  end

  task automatic start(input logic [15:0] c, input logic [3:0] ch);
    @(posedge sys_clk);
    levelBase <= 12'($urandom);
    expMux = c[CTRL_TEMP_BIT] ? TEMP_CHANNEL : ch;
    expDiff = c[CTRL_DIFF_BIT];
    axiWrite(CHANNEL_SELECT_REG, {28'h0, ch}, RESP_OKAY);
    axiWrite(CONVERTER_CONTROL_REG, {16'h0, c}, RESP_OKAY);
  endtask

  task automatic waitIrq(output int k);
    for (k = 0; k < 4000 && irq !== 1'b1; k++) @(negedge sys_clk);
    if (irq !== 1'b1) begin err("no interrupt"); conclude(); end
  endtask

  task automatic quiet(input string s);
    repeat (150) @(negedge sys_clk);
    check1(irq, 1'b0, s);
  endtask

  // Wait for completion, then result, sticky done and its read-clear
  task automatic collect();
    int k;
    logic [11:0] c, v;
    waitIrq(k);
    if (ctl[12:8] == 5'h0) check1(k < SAMPLE_BUDGET_CYCLES, 1, "too slow");
    c = levelBase + 12'(expMux) * 12'h111;
    v = {~c[11], ~c[11], c[10:1]};
    if (expDiff) begin
      axiRead(CONVERTER_RESULT_REG, {{4{v[11]}}, v, 16'h0}, '1, RESP_OKAY);
    end else begin
      axiRead(CONVERTER_RESULT_REG, {4'h0, c, 16'h0}, '1, RESP_OKAY);
    end
    axiRead(IRQ_STATUS_REG, 32'h1, 32'h1, RESP_OKAY);
    repeat (2) @(negedge sys_clk);
    check1(irq, 1'b0, "interrupt not cleared");
  endtask

  initial begin
    void'($urandom(81));
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    axiRead(CONVERTER_CONTROL_REG, {16'h0, CTRL_RESET}, '1, RESP_OKAY);
    axiRead(CHANNEL_SELECT_REG, 32'h0, '1, RESP_OKAY);
    axiRead(IRQ_MASK_REG, 32'h0, '1, RESP_OKAY);
    // Result and status take writes but keep their contents
    axiWrite(CONVERTER_RESULT_REG, 32'hFFFFFFFF, RESP_OKAY);
    axiWrite(IRQ_STATUS_REG, 32'hFFFFFFFF, RESP_OKAY);
    axiRead(CONVERTER_RESULT_REG, 32'h0, '1, RESP_OKAY);
    axiRead(8'h14, 32'h0, '1, RESP_SLVERR);
    axiWrite(8'h14, 32'hFFFFFFFF, RESP_SLVERR);
    axiWrite(CONVERTER_CONTROL_REG, 32'h0000C600, RESP_OKAY);
    axiRead(CONVERTER_CONTROL_REG, 32'h00000600, '1, RESP_OKAY);
    // Masked completion stays silent until the mask opens
    ctl = 16'h0084;
    start(ctl, 4'h3);
    quiet("masked interrupt seen");
    axiWrite(IRQ_MASK_REG, 32'h1, RESP_OKAY);
    collect();
    // Every divider, acquisition length, both modes, temperature last
    for (int i = 0; i < 6; i++) begin
      ctl = 16'(i << 10) | 16'((i % 4) << 8) | 16'h0080 | 16'(CONV_SINGLE);
      if (i % 2 == 1) ctl |= 16'h0040;
      if (i == 5) ctl |= 16'h2000;
      start(ctl, 4'($urandom_range(0, 11)));
      collect();
    end
    // Continuous run survives clearing the start enable, stops on a new kind
    ctl = 16'h0085;
    start(ctl, 4'h5);
    collect();
    axiWrite(CONVERTER_CONTROL_REG, 32'h00000005, RESP_OKAY);
    axiRead(IRQ_STATUS_REG, 32'h2, 32'h2, RESP_OKAY);
    waitIrq(n);
    axiWrite(CONVERTER_CONTROL_REG, 32'h00000000, RESP_OKAY);
    repeat (150) @(negedge sys_clk);
    axiRead(IRQ_STATUS_REG, 32'h0, 32'h2, RESP_OKAY);
    quiet("conversion after stop");
    // Each trigger source starts only its own kind
    for (int k = 0; k < 4; k++) begin
      ctl = 16'h0080 | 16'(kinds[k]);
      start(ctl, 4'(k));
      trig((k + 1) % 4);
      quiet("foreign trigger started");
      trig(k);
      collect();
    end
    // Without the start enable a trigger is refused
    ctl = 16'(CONV_TIMER_A);
    start(ctl, 4'h1);
    trig(1);
    quiet("start without enable");
    conclude();
  end

  task automatic trig(input int k);
    @(posedge sys_clk);
    case (k)
      0: extConversionTriggerPin <= 1'b1;
      1: generalTimerAOvf <= 1'b1;
      2: generalTimerBOvf <= 1'b1;
      default: logicArrayOut <= 1'b1;
    endcase
    @(posedge sys_clk);
    generalTimerAOvf <= 1'b0;
    generalTimerBOvf <= 1'b0;
    logicArrayOut <= 1'b0;
    // Pin held long enough to pass its synchroniser
    repeat (5) @(posedge sys_clk);
    extConversionTriggerPin <= 1'b0;
  endtask
endmodule
`default_nettype wire
